// *** rtl/cijle_alu.sv ***
/*
  Result and flag unit: increment, 8-bit load, 16-bit load.
  Assumes a combinational path; no state of its own.
*/
`timescale 1ns/1ps
`include "cijle_cfg.svh"
module cijle_alu
(
  cijle_alu_if.alu alu_if
);
  // Result and V, N, Z per operation
  always_comb
  begin
    alu_if.result = alu_if.operand;
    alu_if.flag_v = 1'b0;
    alu_if.flag_n = alu_if.operand[7];
    alu_if.flag_z = (alu_if.operand[7:0] == 8'h00);
    case (alu_if.op)
      cijle_pkg::ALU_INC8:
      begin
        alu_if.result = {8'h00, alu_if.operand[7:0] + `CIJLE_INC_STEP};
        alu_if.flag_v = (alu_if.operand[7:0] == `CIJLE_INC_VOPND);
        alu_if.flag_n = alu_if.result[7];
        alu_if.flag_z = (alu_if.result[7:0] == 8'h00);
      end
      cijle_pkg::ALU_LD16:
      begin
        // sign bit 15, all sixteen zero
        alu_if.flag_n = alu_if.operand[15];
        alu_if.flag_z = (alu_if.operand == 16'h0000);
      end
      default:
        alu_if.result = {8'h00, alu_if.operand[7:0]};
    endcase
  end
endmodule // cijle_alu

// *** rtl/cijle_alu_if.sv ***
/*
  Carrier between the sequencer and its flag/result unit.
  Assumes the sequencer drives operation and operand.
*/
`timescale 1ns/1ps
interface cijle_alu_if;
  cijle_pkg::cijle_alu_op_t op;
  logic [15:0]              operand;
  logic [15:0]              result;
  logic                     flag_v;
  logic                     flag_n;
  logic                     flag_z;
  modport alu  (input op, operand, output result, flag_v, flag_n, flag_z);
  modport core (output op, operand, input result, flag_v, flag_n, flag_z);
endinterface

// *** rtl/cijle_cfg.svh ***
/*
  Constants of the increment, jump and load execution unit: opcode
  fields, flag positions, reset values and arithmetic steps.
  Assumes inclusion by both design modules; definitions only.
*/
`ifndef CIJLE_CFG_SVH
`define CIJLE_CFG_SVH
// Opcode pages
`define CIJLE_PAGE0      8'h00
`define CIJLE_PREFIX     8'h9E
// Low nibbles of the families
`define CIJLE_LO_INC     4'hC
`define CIJLE_LO_JUMP    4'hC
`define CIJLE_LO_CALL    4'hD
`define CIJLE_LO_LD_A    4'h6
`define CIJLE_LO_LD_X    4'hE
// High nibbles: modes of jump, call and 8-bit loads
`define CIJLE_M_IMD      4'hA
`define CIJLE_M_DIR      4'hB
`define CIJLE_M_ABS      4'hC
`define CIJLE_M_IXW      4'hD
`define CIJLE_M_IXB      4'hE
`define CIJLE_M_IX       4'hF
// High nibbles: modes of increment
`define CIJLE_I_DIR      4'h3
`define CIJLE_I_A        4'h4
`define CIJLE_I_X        4'h5
`define CIJLE_I_IXB      4'h6
`define CIJLE_I_IX       4'h7
// Index pair loads on page zero
`define CIJLE_HX_IMD     8'h45
`define CIJLE_HX_DIR     8'h55
`define CIJLE_HX_ABS     8'h32
// Second bytes of prefixed opcodes
`define CIJLE_P_INC      8'h6C
`define CIJLE_P_LD_A_SW  8'hD6
`define CIJLE_P_LD_A_SB  8'hE6
`define CIJLE_P_LD_X_SW  8'hDE
`define CIJLE_P_LD_X_SB  8'hEE
`define CIJLE_P_HX_IX    8'hAE
`define CIJLE_P_HX_IXW   8'hBE
`define CIJLE_P_HX_IXB   8'hCE
`define CIJLE_P_HX_SB    8'hFE
// Arithmetic
`define CIJLE_INC_STEP   8'h01
`define CIJLE_INC_VOPND  8'h7F
`define CIJLE_SP_STEP    16'h0001
// Flag positions in the condition code register
`define CIJLE_CC_V       7
`define CIJLE_CC_N       2
`define CIJLE_CC_Z       1
`define CIJLE_CC_C       0
// Reset values
`define CIJLE_SP_RST     16'h00FF
`define CIJLE_PC_RST     16'h0000
`define CIJLE_CC_RST     8'h60
`endif

// *** rtl/cijle_exec.sv ***
/*
  Execution unit for increment, jump, subroutine call and loads.
  Holds A, H:X, SP, PC and the condition codes; runs one bus cycle
  per clock. Assumes fetch hands over the opcode and addressing-mode
  logic hands over the effective address and immediate operand, and
  that memory answers a read within the cycle it is addressed.
*/
// Functional notes
// - Increment adds one to A, X or memory; V,N,Z updated, carry kept.
// - Increment overflow is set exactly when the operand was 7F.
// - Byte results: N is bit 7, Z when all eight bits zero.
// - Index-low increment leaves the high index byte untouched.
// - Increment opcodes and their cycle counts decode as tabulated.
// - Jump loads PC with effective address, flags kept; counts tabulated.
// - Call advances PC past itself, pushes low then high byte.
// - Stack pointer drops once per push, ends at next empty slot.
// - Call then loads PC with effective address; counts tabulated.
// - Accumulator load copies byte, sets N and Z, clears V.
// - Index pair load: first byte to high, next byte to low.
// - Index pair load: N from bit 15, Z on all zero, V cleared.
// - Index-low load copies byte, sets N and Z, clears V.
`timescale 1ns/1ps
`include "cijle_cfg.svh"
module cijle_exec
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        exec_start_in,
  input  wire logic [15:0] opcode_in,
  input  wire logic [15:0] ea_in,
  input  wire logic [15:0] imm_in,
  input  wire logic [7:0]  bus_rdata_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             illegal_out,
  output logic             bus_rd_out,
  output logic             bus_wr_out,
  output logic [15:0]      bus_addr_out,
  output logic [7:0]       bus_wdata_out,
  output logic [2:0]       bus_kind_out,
  output logic [7:0]       acc_out,
  output logic [7:0]       index_h_out,
  output logic [7:0]       index_l_out,
  output logic [15:0]      sp_out,
  output logic [15:0]      pc_out,
  output logic [7:0]       cc_out
);
  cijle_pkg::cijle_state_t r;
  cijle_pkg::cijle_state_t n;
  cijle_pkg::cijle_dec_t   d;
  logic                    upd_flags;
  cijle_alu_if             alu_bus ();

  cijle_alu u_alu (.alu_if (alu_bus));

  // Builds one decode entry
  function automatic cijle_pkg::cijle_dec_t mk(input cijle_pkg::cijle_op_t op,
      input int pre, input int stk, input int rd, input int fr, input int wr,
      input int post, input int len);
    mk.op        = op;
    mk.plan.pre  = 2'(pre);
    mk.plan.stk  = 2'(stk);
    mk.plan.rd   = 2'(rd);
    mk.plan.fr   = 1'(fr);
    mk.plan.wr   = 1'(wr);
    mk.plan.post = 2'(post);
    mk.len       = 3'(len);
  endfunction

  // Opcode to operation, cycle plan and length
  function automatic cijle_pkg::cijle_dec_t decode(input logic [15:0] opc);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = opc[7:4];
    lo = opc[3:0];
    decode = mk(cijle_pkg::OP_NONE, 0, 0, 0, 0, 0, 0, 1);
    if (opc[15:8] == `CIJLE_PAGE0)
    begin
      if (lo == `CIJLE_LO_INC)
        case (hi)
          `CIJLE_I_DIR, `CIJLE_I_IXB: decode = mk(cijle_pkg::OP_INC_M, 0, 0, 1, 1, 1, 2, 2);
          `CIJLE_I_A:   decode = mk(cijle_pkg::OP_INC_A, 0, 0, 0, 0, 0, 1, 1);
          `CIJLE_I_X:   decode = mk(cijle_pkg::OP_INC_X, 0, 0, 0, 0, 0, 1, 1);
          `CIJLE_I_IX:  decode = mk(cijle_pkg::OP_INC_M, 0, 0, 1, 1, 1, 1, 1);
          default: ;
        endcase
      // jump forms; three fetches after, plus one ahead for ABS and IXW only
      if (lo == `CIJLE_LO_JUMP)
        case (hi)
          `CIJLE_M_DIR, `CIJLE_M_IXB: decode = mk(cijle_pkg::OP_JUMP, 0, 0, 0, 0, 0, 3, 2);
          `CIJLE_M_ABS, `CIJLE_M_IXW: decode = mk(cijle_pkg::OP_JUMP, 1, 0, 0, 0, 0, 3, 3);
          `CIJLE_M_IX:  decode = mk(cijle_pkg::OP_JUMP, 0, 0, 0, 0, 0, 3, 1);
          default: ;
        endcase
      if (lo == `CIJLE_LO_CALL)
        case (hi)
          `CIJLE_M_DIR, `CIJLE_M_IXB: decode = mk(cijle_pkg::OP_CALL, 0, 2, 0, 0, 0, 3, 2);
          `CIJLE_M_ABS, `CIJLE_M_IXW: decode = mk(cijle_pkg::OP_CALL, 1, 2, 0, 0, 0, 3, 3);
          `CIJLE_M_IX:  decode = mk(cijle_pkg::OP_CALL, 0, 2, 0, 0, 0, 3, 1);
          default: ;
        endcase
      // accumulator and index-low loads share modes
      if (lo == `CIJLE_LO_LD_A || lo == `CIJLE_LO_LD_X)
      begin
        case (hi)
          `CIJLE_M_IMD: decode = mk(cijle_pkg::OP_LD_A, 0, 0, 0, 0, 0, 2, 2);
          `CIJLE_M_DIR, `CIJLE_M_IXB: decode = mk(cijle_pkg::OP_LD_A, 0, 0, 1, 0, 0, 2, 2);
          `CIJLE_M_ABS, `CIJLE_M_IXW: decode = mk(cijle_pkg::OP_LD_A, 1, 0, 1, 0, 0, 2, 3);
          `CIJLE_M_IX:  decode = mk(cijle_pkg::OP_LD_A, 0, 0, 1, 1, 0, 1, 1);
          default: ;
        endcase
        if (lo == `CIJLE_LO_LD_X && decode.op != cijle_pkg::OP_NONE)
          decode.op = cijle_pkg::OP_LD_X;
      end
      case (opc[7:0])
        `CIJLE_HX_IMD: decode = mk(cijle_pkg::OP_LD_HX, 0, 0, 0, 0, 0, 3, 3);
        `CIJLE_HX_DIR: decode = mk(cijle_pkg::OP_LD_HX, 0, 0, 2, 0, 0, 2, 2);
        `CIJLE_HX_ABS: decode = mk(cijle_pkg::OP_LD_HX, 1, 0, 2, 0, 0, 2, 3);
        default: ;
      endcase
    end
    else if (opc[15:8] == `CIJLE_PREFIX)
      // Prefixed stack-offset and indexed forms
      case (opc[7:0])
        `CIJLE_P_INC:     decode = mk(cijle_pkg::OP_INC_M, 1, 0, 1, 1, 1, 2, 3);
        `CIJLE_P_LD_A_SW: decode = mk(cijle_pkg::OP_LD_A, 2, 0, 1, 0, 0, 2, 4);
        `CIJLE_P_LD_A_SB: decode = mk(cijle_pkg::OP_LD_A, 1, 0, 1, 0, 0, 2, 3);
        `CIJLE_P_LD_X_SW: decode = mk(cijle_pkg::OP_LD_X, 2, 0, 1, 0, 0, 2, 4);
        `CIJLE_P_LD_X_SB: decode = mk(cijle_pkg::OP_LD_X, 1, 0, 1, 0, 0, 2, 3);
        `CIJLE_P_HX_IX:   decode = mk(cijle_pkg::OP_LD_HX, 1, 0, 2, 1, 0, 1, 2);
        `CIJLE_P_HX_IXW:  decode = mk(cijle_pkg::OP_LD_HX, 2, 0, 2, 0, 0, 2, 4);
        `CIJLE_P_HX_IXB, `CIJLE_P_HX_SB:
          decode = mk(cijle_pkg::OP_LD_HX, 1, 0, 2, 0, 0, 2, 3);
        default: ;
      endcase
  endfunction

  // First phase after cur with a nonzero count
  function automatic cijle_pkg::cijle_phase_t next_phase(
      input cijle_pkg::cijle_phase_t cur, input cijle_pkg::cijle_plan_t p);
    if (cur < cijle_pkg::PH_PRE && p.pre != 2'd0)       next_phase = cijle_pkg::PH_PRE;
    else if (cur < cijle_pkg::PH_STK && p.stk != 2'd0)  next_phase = cijle_pkg::PH_STK;
    else if (cur < cijle_pkg::PH_RD && p.rd != 2'd0)    next_phase = cijle_pkg::PH_RD;
    else if (cur < cijle_pkg::PH_FREE && p.fr)          next_phase = cijle_pkg::PH_FREE;
    else if (cur < cijle_pkg::PH_WR && p.wr)            next_phase = cijle_pkg::PH_WR;
    else if (cur < cijle_pkg::PH_POST && p.post != 2'd0) next_phase = cijle_pkg::PH_POST;
    else                                                next_phase = cijle_pkg::PH_IDLE;
  endfunction

  // Cycle count of one phase
  function automatic logic [1:0] cnt_of(input cijle_pkg::cijle_phase_t ph,
                                        input cijle_pkg::cijle_plan_t p);
    case (ph)
      cijle_pkg::PH_PRE:  cnt_of = p.pre;
      cijle_pkg::PH_STK:  cnt_of = p.stk;
      cijle_pkg::PH_RD:   cnt_of = p.rd;
      cijle_pkg::PH_FREE: cnt_of = {1'b0, p.fr};
      cijle_pkg::PH_WR:   cnt_of = {1'b0, p.wr};
      cijle_pkg::PH_POST: cnt_of = p.post;
      default:            cnt_of = 2'd0;
    endcase
  endfunction

  // Flag unit operation and operand
  assign alu_bus.op = (r.op == cijle_pkg::OP_LD_HX) ? cijle_pkg::ALU_LD16 :
                      (r.op inside {cijle_pkg::OP_INC_A, cijle_pkg::OP_INC_X,
                                    cijle_pkg::OP_INC_M}) ? cijle_pkg::ALU_INC8 :
                      cijle_pkg::ALU_LD8;
  assign alu_bus.operand = (r.op == cijle_pkg::OP_INC_A) ? {8'h00, r.a} :
                           (r.op == cijle_pkg::OP_INC_X) ? {8'h00, r.x} : r.data;

  // Sequencer, register updates and next bus cycle
  always_comb
  begin
    n         = r;
    n.done    = 1'b0;
    n.illegal = 1'b0;
    upd_flags = 1'b0;
    d         = decode(opcode_in);
    if (r.phase == cijle_pkg::PH_IDLE)
    begin
      if (exec_start_in && d.op == cijle_pkg::OP_NONE)
        n.illegal = 1'b1;
      else if (exec_start_in)
      begin
        n.op    = d.op;
        n.plan  = d.plan;
        n.ea    = ea_in;
        n.data  = imm_in;
        n.cnt   = 2'd0;
        n.pc    = r.pc + {13'h0000, d.len};
        n.phase = next_phase(cijle_pkg::PH_IDLE, d.plan);
      end
    end
    else
    begin
      if (r.phase == cijle_pkg::PH_RD && r.op == cijle_pkg::OP_LD_HX && r.cnt == 2'd0)
        n.data[15:8] = bus_rdata_in;
      else if (r.phase == cijle_pkg::PH_RD)
        n.data[7:0] = bus_rdata_in;
      if (r.phase == cijle_pkg::PH_STK)
        n.sp = r.sp - `CIJLE_SP_STEP;
      upd_flags = (r.phase == cijle_pkg::PH_WR);
      if ({1'b0, r.cnt} + 3'd1 < {1'b0, cnt_of(r.phase, r.plan)})
        n.cnt = r.cnt + 2'd1;
      else
      begin
        n.cnt   = 2'd0;
        n.phase = next_phase(r.phase, r.plan);
        if (n.phase == cijle_pkg::PH_IDLE)
        begin
          n.done    = 1'b1;
          upd_flags = !(r.op inside {cijle_pkg::OP_JUMP, cijle_pkg::OP_CALL,
                                     cijle_pkg::OP_INC_M});
          case (r.op)
            cijle_pkg::OP_INC_A: n.a = alu_bus.result[7:0];
            cijle_pkg::OP_INC_X: n.x = alu_bus.result[7:0];
            cijle_pkg::OP_LD_A:  n.a = r.data[7:0];
            cijle_pkg::OP_LD_X:  n.x = r.data[7:0];
            cijle_pkg::OP_LD_HX: {n.h, n.x} = r.data;
            cijle_pkg::OP_JUMP, cijle_pkg::OP_CALL: n.pc = r.ea;
            default: ;
          endcase
        end
      end
    end
    // V, N, Z from the flag unit; carry kept
    if (upd_flags)
    begin
      n.cc[`CIJLE_CC_V] = alu_bus.flag_v;
      n.cc[`CIJLE_CC_N] = alu_bus.flag_n;
      n.cc[`CIJLE_CC_Z] = alu_bus.flag_z;
    end
    n.busy  = (n.phase != cijle_pkg::PH_IDLE);
    n.rd    = (n.phase == cijle_pkg::PH_RD);
    n.wr    = (n.phase inside {cijle_pkg::PH_WR, cijle_pkg::PH_STK});
    n.addr  = n.pc;
    n.wdata = 8'h00;
    case (n.phase)
      cijle_pkg::PH_PRE, cijle_pkg::PH_POST: n.kind = cijle_pkg::K_P;
      cijle_pkg::PH_FREE: n.kind = cijle_pkg::K_F;
      cijle_pkg::PH_RD:
      begin
        n.kind = cijle_pkg::K_R;
        n.addr = n.ea + {15'h0000, n.cnt[0]};
      end
      cijle_pkg::PH_WR:
      begin
        n.kind  = cijle_pkg::K_W;
        n.addr  = n.ea;
        n.wdata = alu_bus.result[7:0];
      end
      cijle_pkg::PH_STK:
      begin
        n.kind  = cijle_pkg::K_S;
        n.addr  = n.sp;
        n.wdata = (n.cnt == 2'd0) ? n.pc[7:0] : n.pc[15:8];
      end
      default: n.kind = cijle_pkg::K_NONE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      r     <= '0;
      r.sp  <= `CIJLE_SP_RST;
      r.pc  <= `CIJLE_PC_RST;
      r.cc  <= `CIJLE_CC_RST;
    end
    else
      r <= n;
  end

  // Outputs straight from the state register
  assign busy_out      = r.busy;
  assign done_out      = r.done;
  assign illegal_out   = r.illegal;
  assign bus_rd_out    = r.rd;
  assign bus_wr_out    = r.wr;
  assign bus_addr_out  = r.addr;
  assign bus_wdata_out = r.wdata;
  assign bus_kind_out  = r.kind;
  assign acc_out       = r.a;
  assign index_h_out   = r.h;
  assign index_l_out   = r.x;
  assign sp_out        = r.sp;
  assign pc_out        = r.pc;
  assign cc_out        = r.cc;

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic acc;
  assign acc = (r.phase == cijle_pkg::PH_IDLE) && exec_start_in;

  property p_carry_kept;
    1'b1 |=> $stable(r.cc[`CIJLE_CC_C]);
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("carry changed");
  property p_inc_v;
    r.done && r.op == cijle_pkg::OP_INC_A |->
      r.cc[`CIJLE_CC_V] == ($past(r.a) == `CIJLE_INC_VOPND) && r.a == $past(r.a) + 8'h01;
  endproperty
  a_inc_v: assert property (p_inc_v) else $error("increment result or V wrong");
  property p_increment_index_low_op_h;
    r.done && r.op == cijle_pkg::OP_INC_X |-> $stable(r.h) && r.x == $past(r.x) + 8'h01;
  endproperty
  a_increment_index_low_op_h: assert property (p_increment_index_low_op_h) else $error("index high touched");
  property p_load_flags;
    r.done && r.op inside {cijle_pkg::OP_LD_A, cijle_pkg::OP_LD_X} |->
      r.cc[`CIJLE_CC_V] == 1'b0 && r.cc[`CIJLE_CC_Z] == ((r.op == cijle_pkg::OP_LD_A ?
      r.a : r.x) == 8'h00) && r.cc[`CIJLE_CC_N] == (r.op == cijle_pkg::OP_LD_A ? r.a[7] : r.x[7]);
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("load flags wrong");
  property p_hx_flags;
    r.done && r.op == cijle_pkg::OP_LD_HX |-> r.cc[`CIJLE_CC_N] == r.h[7] &&
      r.cc[`CIJLE_CC_Z] == ({r.h, r.x} == 16'h0000) && !r.cc[`CIJLE_CC_V];
  endproperty
  a_hx_flags: assert property (p_hx_flags) else $error("pair load flags wrong");
  // First byte is held in the high half of the operand until completion
  property p_hx_order;
    r.rd && r.op == cijle_pkg::OP_LD_HX && r.cnt == 2'd0 |->
      r.addr == r.ea ##1 r.rd && r.addr == r.ea + 16'h0001
      ##1 r.data[15:8] == $past(bus_rdata_in, 2) && r.data[7:0] == $past(bus_rdata_in);
  endproperty
  a_hx_order: assert property (p_hx_order) else $error("pair byte order wrong");
  property p_push;
    r.kind == cijle_pkg::K_S && r.cnt == 2'd0 |-> r.addr == r.sp && r.wdata == r.pc[7:0]
      ##1 r.kind == cijle_pkg::K_S && r.addr == $past(r.sp) - 16'h0001 && r.wdata == r.pc[15:8]
      ##1 r.sp == $past(r.sp, 2) - 16'h0002;
  endproperty
  a_push: assert property (p_push) else $error("return push wrong");
  property p_jump;
    r.done && r.op inside {cijle_pkg::OP_JUMP, cijle_pkg::OP_CALL} |->
      r.pc == r.ea && r.cc == $past(r.cc);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or flags wrong");
  property p_inc_stk_cycles;
    acc && opcode_in == {`CIJLE_PREFIX, `CIJLE_P_INC} |-> !r.busy ##1 (r.busy && !r.done) [*6]
      ##1 r.done && !r.busy;
  endproperty
  a_inc_stk_cycles: assert property (p_inc_stk_cycles) else $error("increment count");
  property p_call_abs_pattern;
    acc && opcode_in == 16'h00CD |-> ##1 r.kind == cijle_pkg::K_P
      ##1 r.kind == cijle_pkg::K_S [*2] ##1 r.kind == cijle_pkg::K_P [*3] ##1 r.done;
  endproperty
  a_call_abs_pattern: assert property (p_call_abs_pattern) else $error("call pattern");
  c_call: cover property (r.done && r.op == cijle_pkg::OP_CALL);
  c_inc_mem: cover property (r.done && r.op == cijle_pkg::OP_INC_M);
  c_pair_load: cover property (r.done && r.op == cijle_pkg::OP_LD_HX);
  c_illegal: cover property (r.illegal);
endmodule // cijle_exec

// *** rtl/cijle_pkg.sv ***
/*
  Types of the execution unit: operations, sequencer phases, bus
  cycle kinds, cycle plans and the registered state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cijle_pkg;
  typedef enum logic [3:0] {OP_NONE, OP_INC_A, OP_INC_X, OP_INC_M, OP_JUMP,
                            OP_CALL, OP_LD_A, OP_LD_X, OP_LD_HX} cijle_op_t;
  typedef enum logic [2:0] {PH_IDLE, PH_PRE, PH_STK, PH_RD, PH_FREE, PH_WR,
                            PH_POST} cijle_phase_t;
  typedef enum logic [2:0] {K_NONE, K_P, K_R, K_F, K_W, K_S} cijle_kind_t;
  typedef enum logic [1:0] {ALU_INC8, ALU_LD8, ALU_LD16} cijle_alu_op_t;
  // Cycle counts per phase, run in declaration order
  typedef struct packed {
    logic [1:0] pre;
    logic [1:0] stk;
    logic [1:0] rd;
    logic       fr;
    logic       wr;
    logic [1:0] post;
  } cijle_plan_t;
  typedef struct packed {
    cijle_op_t   op;
    cijle_plan_t plan;
    logic [2:0]  len;
  } cijle_dec_t;
  typedef struct packed {
    cijle_phase_t phase;
    logic [1:0]   cnt;
    cijle_plan_t  plan;
    cijle_op_t    op;
    logic [15:0]  ea;
    logic [15:0]  data;
    logic [7:0]   a;
    logic [7:0]   h;
    logic [7:0]   x;
    logic [15:0]  sp;
    logic [15:0]  pc;
    logic [7:0]   cc;
    logic         rd;
    logic         wr;
    logic [15:0]  addr;
    logic [7:0]   wdata;
    cijle_kind_t  kind;
    logic         busy;
    logic         done;
    logic         illegal;
  } cijle_state_t;
endpackage

// *** verif/cijle_mem_model.sv ***
/*
  Behavioural memory and stack on the far side of the execution unit.
  Assumes addresses fit in 256 bytes; reads answer in the same cycle.
*/
`timescale 1ns/1ps
module cijle_mem_model
(
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  output logic [7:0]       rdata_out
);
  logic [7:0] m [256];
  logic [7:0] last_r;
  // Clear storage at start
  initial
  begin
    foreach (m[i]) m[i] = 8'h00;
    last_r = 8'h00;
  end
  // Data and stack writes, last read kept
  always @(posedge clk_in)
  begin
    if (wr_in) m[addr_in[7:0]] <= wdata_in;
    if (rd_in) last_r <= m[addr_in[7:0]];
  end
  // Unselected bus shows inverted last value
  assign rdata_out = rd_in ? m[addr_in[7:0]] : ~last_r;
endmodule // cijle_mem_model

// *** verif/testbench.sv ***
/*
  Self-checking bench of the execution unit with memory model.
  Assumes the unit samples start while idle and pulses done at N+1.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic clk_sys_in, reset_in, start, ill;
  logic [15:0] opc, ea_v, imm_v, sp_e, pc_e;
  logic [7:0] rdata, acc, hh, xx, cc, wdata;
  logic [15:0] addr, sp, pc;
  logic rd, wr, busy_out, done_out, illegal_out;
  logic [2:0] bus_kind_out;
  int mismatches, n_tests, cyc;
  cijle_exec dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .exec_start_in(start),
    .opcode_in(opc), .ea_in(ea_v), .imm_in(imm_v), .bus_rdata_in(rdata),
    .busy_out(busy_out), .done_out(done_out), .illegal_out(illegal_out), .bus_rd_out(rd),
    .bus_wr_out(wr), .bus_addr_out(addr), .bus_wdata_out(wdata), .bus_kind_out(bus_kind_out),
    .acc_out(acc), .index_h_out(hh), .index_l_out(xx), .sp_out(sp), .pc_out(pc), .cc_out(cc));
  cijle_mem_model mem (.clk_in(clk_sys_in), .rd_in(rd), .wr_in(wr), .addr_in(addr),
    .wdata_in(wdata), .rdata_out(rdata));
  // Clock and hang guard
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One instruction; bus kinds per cycle checked against pattern
  task automatic run(input logic [15:0] op, input logic [15:0] ea, input logic [15:0] immediate_mode,
                     input string exp);
    logic [31:0] pat, e;
    pat = 0;
    e = 0;
    ill = 0;
    foreach (exp[i]) e = e * 8 + (exp[i] == "p" ? 1 : exp[i] == "r" ? 2 :
                                  exp[i] == "f" ? 3 : exp[i] == "w" ? 4 : 5);
    @(posedge clk_sys_in);
    start <= 1'b1;
    opc <= op;
    ea_v <= ea;
    imm_v <= immediate_mode;
    @(posedge clk_sys_in);
    start <= 1'b0;
    // First bus cycle stands right after the edge that takes the start
    for (int k = 0; k < 20; k++)
    begin
      #1;
      if (done_out === 1'b1 || illegal_out === 1'b1) break;
      `CHK(busy_out, 1'b1)
      pat = {pat[28:0], bus_kind_out};
      @(posedge clk_sys_in);
    end
    ill = (illegal_out === 1'b1);
    `CHK(pat, e)
  endtask
  task automatic t_acc();
    run(16'h00A6, 0, 16'h007F, "pp"); `CHK({acc, cc}, 16'h7F60)
    run(16'h004C, 0, 0, "p"); `CHK({acc, cc}, 16'h80E4)
    run(16'h004C, 0, 0, "p"); `CHK({acc, cc}, 16'h8164)
    run(16'h00A6, 0, 16'h00FF, "pp"); `CHK(cc, 8'h64)
    run(16'h004C, 0, 0, "p"); `CHK({acc, cc}, 16'h0062)
  endtask
  task automatic t_index();
    run(16'h0045, 0, 16'h12FF, "ppp"); `CHK({hh, xx, cc}, 24'h12FF60)
    run(16'h005C, 0, 0, "p"); `CHK({hh, xx, cc}, 24'h120062)
    mem.m[8'h10] = 8'h80;
    mem.m[8'h11] = 8'h00;
    run(16'h0055, 16'h0010, 0, "rrpp"); `CHK({hh, xx, cc}, 24'h800064)
    run(16'h0045, 0, 16'h0000, "ppp"); `CHK(cc, 8'h62)
    mem.m[8'h20] = 8'h7F;
    run(16'h9EEE, 16'h0020, 0, "prpp"); `CHK({xx, cc}, 16'h7F60)
    run(16'h00B6, 16'h0011, 0, "rpp"); `CHK({acc, cc}, 16'h0062)
  endtask
  task automatic t_inc_mem();
    mem.m[8'h30] = 8'h7F;
    run(16'h003C, 16'h0030, 0, "rfwpp"); `CHK({mem.m[8'h30], cc}, 16'h80E4)
    run(16'h006C, 16'h0030, 0, "rfwpp"); `CHK({mem.m[8'h30], cc}, 16'h8164)
    run(16'h007C, 16'h0030, 0, "rfwp"); `CHK({mem.m[8'h30], cc}, 16'h8264)
    run(16'h9E6C, 16'h0030, 0, "prfwpp"); `CHK({mem.m[8'h30], cc}, 16'h8364)
  endtask
  task automatic t_jump();
    logic [15:0] ops [5] = '{16'h00BC, 16'h00CC, 16'h00DC, 16'h00EC, 16'h00FC};
    string pt [5] = '{"ppp", "pppp", "pppp", "ppp", "ppp"};
    for (int i = 0; i < 5; i++)
    begin
      run(ops[i], 16'h1000 + i, 0, pt[i]); `CHK({pc, cc}, {16'(16'h1000 + i), 8'h64})
    end
    pc_e = 16'h1004;
  endtask
  task automatic t_call();
    logic [15:0] ops [5] = '{16'h00BD, 16'h00CD, 16'h00DD, 16'h00ED, 16'h00FD};
    logic [15:0] len [5] = '{16'h0002, 16'h0003, 16'h0003, 16'h0002, 16'h0001};
    string pt [5] = '{"ssppp", "pssppp", "pssppp", "ssppp", "ssppp"};
    for (int i = 0; i < 5; i++)
    begin
      run(ops[i], 16'h2000 + i, 0, pt[i]); `CHK({pc, cc}, {16'(16'h2000 + i), 8'h64})
      pc_e = pc_e + len[i];
      `CHK(mem.m[sp_e[7:0]], pc_e[7:0])
      `CHK(mem.m[sp_e[7:0] - 8'h01], pc_e[15:8])
      sp_e = sp_e - 16'h0002;
      `CHK(sp, sp_e)
      pc_e = 16'h2000 + i;
    end
  endtask
  task automatic t_illegal();
    run(16'h0001, 0, 0, ""); `CHK({ill, acc, pc}, {1'b1, 8'h00, pc_e})
  endtask
  // Reset then scenarios
  initial
  begin
    reset_in = 1'b1;
    start = 1'b0;
    opc = 0;
    ea_v = 0;
    imm_v = 0;
    sp_e = 16'h00FF;
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_acc();
    t_index();
    t_inc_mem();
    t_jump();
    t_call();
    t_illegal();
    conclude();
  end
endmodule // testbench
